// >>> inc/tlf_pkg.sv
// Shared constants and a helper function for the temperature limit block
package tlf_pkg;

    // Register pointer values
    localparam logic [2:0] PTR_CONFIG   = 3'h1;
    localparam logic [2:0] PTR_HIGH_LIM = 3'h2;
    localparam logic [2:0] PTR_LOW_LIM  = 3'h3;
    localparam logic [2:0] PTR_CRIT_LIM = 3'h4;
    localparam logic [2:0] PTR_TEMP     = 3'h5;

    // Temperature word layout
    localparam int TEMP_W       = 13;   // Sign plus 12 magnitude bits
    localparam int LIMIT_W      = 11;   // Sign plus 10 magnitude bits
    localparam int SIGN_BIT     = 12;
    localparam int LIMIT_LSB    = 2;
    localparam int FLAG_CRIT    = 15;
    localparam int FLAG_HIGH    = 14;
    localparam int FLAG_LOW     = 13;

    // Configuration word layout
    localparam int CFG_MODE     = 0;
    localparam int CFG_POL      = 1;
    localparam int CFG_CRIT_ONLY = 2;
    localparam int CFG_EV_EN    = 3;
    localparam int CFG_EV_STS   = 4;
    localparam int CFG_CLEAR    = 5;
    localparam int CFG_EV_LOCK  = 6;
    localparam int CFG_CRIT_LOCK = 7;
    localparam int CFG_SHDN     = 8;
    localparam int CFG_HYST_LSB = 9;

    // Reset values
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [10:0] RST_LIMIT = 11'h000;
    localparam logic [12:0] RST_TEMP  = 13'h0000;

    // Place a limit on the bit weights of the measured value, low bits zero
    function automatic logic signed [12:0] tlf_align_limit(input logic [10:0] lim);
        tlf_align_limit = {lim, 2'b00};
    endfunction : tlf_align_limit

endpackage : tlf_pkg

// >>> verilog/tlf_cmp.sv
// Signed comparison of the measured value against one trip limit
`timescale 1ns/100ps
module tlf_cmp (
    input  wire logic [tlf_pkg::TEMP_W-1:0]  temp_i,
    input  wire logic [tlf_pkg::LIMIT_W-1:0] limit_i,
    output logic                             above_o,
    output logic                             equal_o
);
    import tlf_pkg::*;

    logic signed [TEMP_W-1:0] temp_s;
    logic signed [TEMP_W-1:0] limit_s;

    // Two's complement compare on common weights
    always_comb begin
        temp_s  = $signed(temp_i);
        limit_s = tlf_align_limit(limit_i);
        above_o = temp_s > limit_s;
        equal_o = temp_s == limit_s;
    end

endmodule : tlf_cmp

// >>> verilog/tlf_top.sv
// Temperature result, trip limits, event logic and register port
`timescale 1ns/100ps

module tlf_top (
    input  wire logic                        clk_sys_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        sample_valid_i,
    input  wire logic [tlf_pkg::TEMP_W-1:0]  sample_i,
    input  wire logic [2:0]                  reg_ptr_i,
    input  wire logic                        reg_wr_i,
    input  wire logic [15:0]                 reg_wdata_i,
    input  wire logic                        reg_rd_i,
    output logic      [15:0]                 reg_rdata_o,
    output logic                             reg_rvalid_o,
    output logic                             event_o,
    output logic                             event_oe_o
);
    import tlf_pkg::*;

    typedef struct packed {
        logic                mode;        // 1 = interrupt, 0 = comparator
        logic                pol;         // 1 = event active high
        logic                crit_only;
        logic                ev_en;
        logic                ev_lock;
        logic                crit_lock;
        logic                shdn;
        logic [1:0]          hyst;        // Stored only
        logic [LIMIT_W-1:0]  high_lim;
        logic [LIMIT_W-1:0]  low_lim;
        logic [LIMIT_W-1:0]  crit_lim;
        logic [TEMP_W-1:0]   temp;
        logic                cond_q;
        logic                ev_rec;
        logic                clr_pend;
        logic [15:0]         rdata;
        logic                rvalid;
        logic                ev_oe;
        logic                pin_lvl;     // Open drain, held low
    } tlf_state_type;

    tlf_state_type st;
    tlf_state_type next_st;

    logic hi_above;
    logic hi_equal;
    logic lo_above;
    logic lo_equal;
    logic cr_above;
    logic cr_equal;
    logic flag_crit;
    logic flag_high;
    logic flag_low;
    logic cond;
    logic active;
    logic asserted;
    logic locked;
    logic clear_req;
    logic [15:0] cfg_word;

    // One comparator per trip limit, signed on common weights
    tlf_cmp u_cmp_high (
        .temp_i  (st.temp),
        .limit_i (st.high_lim),
        .above_o (hi_above),
        .equal_o (hi_equal)
    );

    tlf_cmp u_cmp_low (
        .temp_i  (st.temp),
        .limit_i (st.low_lim),
        .above_o (lo_above),
        .equal_o (lo_equal)
    );

    tlf_cmp u_cmp_crit (
        .temp_i  (st.temp),
        .limit_i (st.crit_lim),
        .above_o (cr_above),
        .equal_o (cr_equal)
    );

    // Limit flags follow both temperature and limit changes at once
    always_comb begin
        flag_crit = cr_above | cr_equal;
        flag_high = hi_above;
        flag_low  = ~(lo_above | lo_equal);
        cond      = flag_crit | (~st.crit_only & (flag_high | flag_low));
        // Comparator mode tracks the condition, interrupt mode the record
        active    = st.mode ? st.ev_rec : cond;
        asserted  = st.ev_en & active;
        locked    = st.ev_lock | st.crit_lock;
        clear_req = reg_wr_i && reg_ptr_i == PTR_CONFIG && reg_wdata_i[CFG_CLEAR];
    end

    // Configuration readback; clear bit never reads back as one
    always_comb begin
        cfg_word = RST_WORD;
        cfg_word[CFG_MODE]      = st.mode;
        cfg_word[CFG_POL]       = st.pol;
        cfg_word[CFG_CRIT_ONLY] = st.crit_only;
        cfg_word[CFG_EV_EN]     = st.ev_en;
        cfg_word[CFG_EV_STS]    = asserted;
        cfg_word[CFG_CLEAR]     = 1'b0;
        cfg_word[CFG_EV_LOCK]   = st.ev_lock;
        cfg_word[CFG_CRIT_LOCK] = st.crit_lock;
        cfg_word[CFG_SHDN]      = st.shdn;
        cfg_word[CFG_HYST_LSB+1:CFG_HYST_LSB] = st.hyst;
    end

    // Next-state logic
    always_comb begin
        next_st        = st;
        next_st.rvalid = 1'b0;

        // New conversion result unless the sensor is shut down
        if (sample_valid_i && !st.shdn) begin
            next_st.temp = sample_i;
        end

        // Register writes
        if (reg_wr_i) begin
            case (reg_ptr_i)
                PTR_CONFIG: begin
                    if (!locked) begin
                        next_st.mode = reg_wdata_i[CFG_MODE];
                        next_st.pol  = reg_wdata_i[CFG_POL];
                        next_st.ev_en = reg_wdata_i[CFG_EV_EN];
                        next_st.hyst = reg_wdata_i[CFG_HYST_LSB+1:CFG_HYST_LSB];
                        if (!st.ev_lock || !reg_wdata_i[CFG_CRIT_ONLY]) begin
                            next_st.crit_only = reg_wdata_i[CFG_CRIT_ONLY];
                        end
                    end
                    // Shutdown may always be left, entered only when unlocked
                    if (!reg_wdata_i[CFG_SHDN] || !locked) begin
                        next_st.shdn = reg_wdata_i[CFG_SHDN];
                    end
                    // Locks are sticky until reset
                    if (reg_wdata_i[CFG_EV_LOCK]) begin
                        next_st.ev_lock = 1'b1;
                    end
                    if (reg_wdata_i[CFG_CRIT_LOCK]) begin
                        next_st.crit_lock = 1'b1;
                    end
                end
                PTR_HIGH_LIM: begin
                    if (!st.ev_lock) begin
                        next_st.high_lim = reg_wdata_i[SIGN_BIT:LIMIT_LSB];
                    end
                end
                PTR_LOW_LIM: begin
                    if (!st.ev_lock) begin
                        next_st.low_lim = reg_wdata_i[SIGN_BIT:LIMIT_LSB];
                    end
                end
                PTR_CRIT_LIM: begin
                    if (!st.crit_lock) begin
                        next_st.crit_lim = reg_wdata_i[SIGN_BIT:LIMIT_LSB];
                    end
                end
                default: begin
                end
            endcase
        end

        // Event record: clear handling first so that a new event wins
        next_st.cond_q = cond;
        if (st.mode) begin
            if (clear_req) begin
                if (flag_crit) begin
                    next_st.clr_pend = 1'b1;
                end else begin
                    next_st.ev_rec   = 1'b0;
                    next_st.clr_pend = 1'b0;
                end
            end else if (st.clr_pend && !flag_crit) begin
                next_st.ev_rec   = 1'b0;
                next_st.clr_pend = 1'b0;
            end
            if (cond && !st.cond_q) begin
                next_st.ev_rec = 1'b1;
            end
        end else begin
            // Clear has no effect in comparator mode
            next_st.ev_rec   = 1'b0;
            next_st.clr_pend = 1'b0;
        end

        // Open-drain pin: disabled low-polarity floats, high-polarity grounds
        next_st.ev_oe = st.pol ? ~asserted : asserted;
        next_st.pin_lvl = 1'b0;                                     // Never drives high

        // Register reads
        if (reg_rd_i) begin
            next_st.rvalid = 1'b1;
            case (reg_ptr_i)
                PTR_CONFIG:   next_st.rdata = cfg_word;
                PTR_HIGH_LIM: next_st.rdata = {3'h0, st.high_lim, 2'h0};
                PTR_LOW_LIM:  next_st.rdata = {3'h0, st.low_lim, 2'h0};
                PTR_CRIT_LIM: next_st.rdata = {3'h0, st.crit_lim, 2'h0};
                PTR_TEMP:     next_st.rdata = {flag_crit, flag_high, flag_low,
                                               st.temp};
                default:      next_st.rdata = RST_WORD;
            endcase
        end
    end

    // State register; everything writable starts at zero
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st          <= '0;
            st.high_lim <= RST_LIMIT;
            st.low_lim  <= RST_LIMIT;
            st.crit_lim <= RST_LIMIT;
            st.temp     <= RST_TEMP;
            st.rdata    <= RST_WORD;
        end else begin
            st <= next_st;
        end
    end

    // Pin output level is always low; the enable carries the event
    assign event_o      = st.pin_lvl;
    assign reg_rdata_o  = st.rdata;
    assign reg_rvalid_o = st.rvalid;
    assign event_oe_o   = st.ev_oe;

endmodule : tlf_top

// >>> dv/tlf_top_props.sv
// Assertion checker on the temperature limit block ports
`timescale 1ns/100ps
module tlf_top_props import tlf_pkg::*; (
    input wire logic        clk_sys_i,
    input wire logic        rst_n_i,
    input wire logic        sample_valid_i,
    input wire logic [12:0] sample_i,
    input wire logic [2:0]  reg_ptr_i,
    input wire logic        reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic        reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        reg_rvalid_o,
    input wire logic        event_o,
    input wire logic        event_oe_o
);
    logic [12:0] last_s;
    logic        shdn_seen;
    // Sample mirror, trusted only while shutdown was never asked for
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            last_s    <= 13'h0000;
            shdn_seen <= 1'b0;
        end else begin
            if (sample_valid_i) last_s <= sample_i;
            if (reg_wr_i && reg_ptr_i == PTR_CONFIG && reg_wdata_i[CFG_SHDN]) shdn_seen <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    property p_rd_ack; reg_rd_i |=> reg_rvalid_o; endproperty
    a_rd_ack: assert property (p_rd_ack) else $error("read not answered");
    property p_one_shot; !reg_rd_i |=> !reg_rvalid_o; endproperty
    a_one_shot: assert property (p_one_shot) else $error("valid without read");
    property p_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_lim_lsb; reg_rd_i && reg_ptr_i inside {[PTR_HIGH_LIM:PTR_CRIT_LIM]}
        |=> reg_rdata_o[1:0] == 2'h0; endproperty
    a_lim_lsb: assert property (p_lim_lsb) else $error("limit low bits set");
    property p_crit_top; reg_rd_i && reg_ptr_i == PTR_CRIT_LIM |=> reg_rdata_o[15:13] == 3'h0;
    endproperty
    a_crit_top: assert property (p_crit_top) else $error("critical top bits set");
    property p_clear_rd; reg_rd_i && reg_ptr_i == PTR_CONFIG |=> !reg_rdata_o[CFG_CLEAR];
    endproperty
    a_clear_rd: assert property (p_clear_rd) else $error("clear bit read one");
    property p_temp; reg_rd_i && reg_ptr_i == PTR_TEMP && !shdn_seen
        |=> reg_rdata_o[12:0] == $past(last_s); endproperty
    a_temp: assert property (p_temp) else $error("temperature field wrong");
    property p_unmapped; reg_rd_i && reg_ptr_i inside {3'h0, 3'h6, 3'h7}
        |=> reg_rdata_o == 16'h0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_pin_low; event_oe_o |-> event_o == 1'b0; endproperty
    a_pin_low: assert property (p_pin_low) else $error("event pin driven high");
    c_crit: cover property (reg_rd_i && reg_ptr_i == PTR_TEMP ##1 reg_rdata_o[FLAG_CRIT]);
    c_event: cover property ($rose(event_oe_o));
    c_clear: cover property (reg_wr_i && reg_ptr_i == PTR_CONFIG && reg_wdata_i[CFG_CLEAR]);
endmodule : tlf_top_props

bind tlf_top tlf_top_props u_props (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .sample_valid_i(sample_valid_i), .sample_i(sample_i), .reg_ptr_i(reg_ptr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .event_o(event_o),
    .event_oe_o(event_oe_o));

// >>> dv/tlf_host.sv
// Host model for the register port and the pulled-up event line
`timescale 1ns/100ps
module tlf_host (
    input  wire logic   clk_sys_i,
    output logic [2:0]  reg_ptr_o,
    output logic        reg_wr_o,
    output logic [15:0] reg_wdata_o,
    output logic        reg_rd_o,
    input  wire logic   event_o,
    input  wire logic   event_oe_o,
    output logic        event_pin_o
);
    // Pull-up wins whenever the block lets go of the line
    assign event_pin_o = event_oe_o ? event_o : 1'b1;
    initial begin
        reg_ptr_o   = 3'h0;
        reg_wr_o    = 1'b0;
        reg_wdata_o = 16'h0000;
        reg_rd_o    = 1'b0;
    end
    // One strobe cycle; idle lines get inverted so stale values cannot pass
    task automatic acc(input logic wr, input logic [2:0] p, input logic [15:0] d);
        @(negedge clk_sys_i);
        reg_wr_o    = wr;
        reg_rd_o    = !wr;
        reg_ptr_o   = p;
        reg_wdata_o = d;
        @(negedge clk_sys_i);
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_ptr_o   = ~p;
        reg_wdata_o = ~d;
    endtask : acc
endmodule : tlf_host

// >>> dv/tlf_top_test.sv
// Self-checking bench for the temperature limit block
`timescale 1ns/100ps
module tlf_top_test;
    import tlf_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic sample_valid_i = 1'b0;
    logic [12:0] sample_i = 13'h0000;
    logic [2:0] reg_ptr_i;
    logic reg_wr_i, reg_rd_i, reg_rvalid_o, event_o, event_oe_o, pin;
    logic [15:0] reg_wdata_i, reg_rdata_o;
    logic signed [12:0] hi, lo, cr;
    logic [12:0] s;
    logic [12:0] bnd[8] = '{13'h0500, 13'h04FF, 13'h0300, 13'h0301,
                            13'h0100, 13'h00FF, 13'h1C90, 13'h0000};
    logic [15:0] expq[$];
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    always #4 clk_sys_i = ~clk_sys_i;
    tlf_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sample_valid_i(sample_valid_i),
        .sample_i(sample_i), .reg_ptr_i(reg_ptr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .event_o(event_o), .event_oe_o(event_oe_o));
    tlf_host host (.clk_sys_i(clk_sys_i), .reg_ptr_o(reg_ptr_i), .reg_wr_o(reg_wr_i),
        .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i), .event_o(event_o),
        .event_oe_o(event_oe_o), .event_pin_o(pin));
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic rd(input logic [2:0] p, input logic [15:0] x);
        expq.push_back(x);
        host.acc(1'b0, p, 16'h0000);
    endtask : rd
    // Two idle cycles let status and the pin settle after a write
    task automatic wr(input logic [2:0] p, input logic [15:0] v);
        host.acc(1'b1, p, v);
        repeat (2) @(negedge clk_sys_i);
    endtask : wr
    task automatic wlim(input logic [2:0] p, input logic [15:0] v);
        wr(p, v);
        if (p == PTR_HIGH_LIM) hi = v[12:0] & 13'h1FFC;
        if (p == PTR_LOW_LIM) lo = v[12:0] & 13'h1FFC;
        if (p == PTR_CRIT_LIM) cr = v[12:0] & 13'h1FFC;
        rd(p, v & 16'h1FFC);
    endtask : wlim
    task automatic smp(input logic [12:0] v);
        @(negedge clk_sys_i);
        sample_valid_i = 1'b1;
        sample_i = v;
        @(negedge clk_sys_i);
        sample_valid_i = 1'b0;
        sample_i = ~v;
        repeat (3) @(negedge clk_sys_i);
    endtask : smp
    function automatic logic [15:0] tword(input logic signed [12:0] t);
        tword = {t >= cr, t > hi, t < lo, t};
    endfunction : tword
    // Answers are paired with the oldest note while valid stands
    always @(negedge clk_sys_i) begin
        if (reg_rvalid_o === 1'b1) begin
            if (expq.size() == 0) chk("spare answer", 16'h0001, 16'h0000);
            else chk("read data", reg_rdata_o, expq.pop_front());
        end
    end
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc > 4000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        void'($urandom(47));
        repeat (5) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        hi = 0;
        lo = 0;
        cr = 0;
        for (int p = 0; p < 8; p++) rd(3'(p), (p == 5) ? 16'h8000 : 16'h0000);
        $display("reset values done");
        for (int i = 0; i < 9; i++) wlim(PTR_HIGH_LIM + 3'(i % 3), 16'($urandom()));
        for (int i = 0; i < 8; i++) begin
            s = 13'($urandom());
            smp(s);
            rd(PTR_TEMP, tword(s));
        end
        $display("random limits done");
        wlim(PTR_HIGH_LIM, 16'h0300);
        wlim(PTR_LOW_LIM, 16'h0100);
        wlim(PTR_CRIT_LIM, 16'h0500);
        foreach (bnd[k]) begin
            smp(bnd[k]);
            rd(PTR_TEMP, tword(bnd[k]));
        end
        $display("boundaries done");
        // Leave the alarm window first so interrupt mode sees a rising condition
        smp(13'h0200);
        wr(PTR_CONFIG, 16'h0009);
        smp(13'h0320);
        chk("pin", 16'(pin), 16'h0000);
        smp(13'h0200);
        rd(PTR_CONFIG, 16'h0019);
        wr(PTR_CONFIG, 16'h0029);
        rd(PTR_CONFIG, 16'h0009);
        smp(13'h0600);
        wr(PTR_CONFIG, 16'h0029);
        rd(PTR_CONFIG, 16'h0019);
        smp(13'h0200);
        rd(PTR_CONFIG, 16'h0009);
        chk("pin", 16'(pin), 16'h0001);
        wr(PTR_CONFIG, 16'h0008);
        smp(13'h0600);
        wr(PTR_CONFIG, 16'h0028);
        rd(PTR_CONFIG, 16'h0018);
        wr(PTR_CONFIG, 16'h000A);
        chk("pin", 16'(pin), 16'h0001);
        smp(13'h0200);
        chk("pin", 16'(pin), 16'h0000);
        $display("event modes done");
        // Critical-only mode ignores the alarm window
        wr(PTR_CONFIG, 16'h000C);
        smp(13'h0320);
        rd(PTR_CONFIG, 16'h000C);
        smp(13'h0600);
        rd(PTR_CONFIG, 16'h001C);
        chk("pin", 16'(pin), 16'h0000);
        // Shutdown freezes the last accepted sample
        wr(PTR_CONFIG, 16'h0100);
        smp(13'h0200);
        rd(PTR_TEMP, tword(13'h0600));
        $display("critical only and shutdown done");
        wr(PTR_CONFIG, 16'h0080);
        wr(PTR_CRIT_LIM, 16'h0123);
        rd(PTR_CRIT_LIM, 16'h0500);
        rd(PTR_CONFIG, 16'h0080);
        @(negedge clk_sys_i);
        rst_n_i = 1'b0;
        repeat (5) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        rd(PTR_CRIT_LIM, 16'h0000);
        rd(PTR_CONFIG, 16'h0000);
        repeat (3) @(negedge clk_sys_i);
        chk("pending answers", 16'(expq.size()), 16'h0000);
        $display("lock and reset done");
        end_of_test();
    end
endmodule : tlf_top_test
